// >>> src/ast_pkg.sv
// Purpose: constants shared by the converter start and result control
// Assumes: 32-bit register port, byte addresses as printed
// Notes: offsets, field positions, reset values and start codes
package ast_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [31:0] CONVERSION_CONTROL_ADDR = 32'h4001_C000;
	localparam logic [31:0] LATEST_RESULT_ADDR = 32'h4001_C004;

	////////////////////////////////////////////////////////////////////////////////
	// conversion_control fields
	localparam int CTL_SEL_LSB = 0;
	localparam int CTL_SCAN_BIT = 16;
	localparam int CTL_RES_LSB = 17;
	localparam int CTL_POWER_BIT = 21;
	localparam int CTL_START_LSB = 24;
	localparam int CTL_EDGE_BIT = 27;

	////////////////////////////////////////////////////////////////////////////////
	// latest_result fields
	localparam int RES_VALUE_LSB = 6;
	localparam int RES_CHAN_LSB = 24;
	localparam int RES_OVERRUN_BIT = 30;
	localparam int RES_DONE_BIT = 31;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] SEL_RESET = 8'h01;
	localparam logic [2:0] RES_SELECT_RESET = 3'h0;
	localparam logic [2:0] START_RESET = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// start select codes
	localparam logic [2:0] START_NONE = 3'h0;
	localparam logic [2:0] START_NOW = 3'h1;
	localparam logic [2:0] START_FIRST_TIMER = 3'h2;

	typedef enum logic [1:0] {
		AST_IDLE = 2'b01,
		AST_BUSY = 2'b10
	} ast_state_t;

	typedef struct packed {
		logic [7:0] ctrlSel;
		logic ctrlScan;
		logic [2:0] ctrlScanRes;
		logic ctrlPower;
		logic [2:0] ctrlStart;
		logic ctrlEdge;
		logic [5:0] trigPrev;
		ast_state_t state;
		logic scanActive;
		logic [2:0] curChan;
		logic [9:0] resValue;
		logic [2:0] resChan;
		logic resOverrun;
		logic resDone;
		logic startPulse;
		logic [31:0] rdData;
	} ast_regs_t;

endpackage : ast_pkg

// >>> src/ast_start_ctrl.sv
// Purpose: start-source selection, edge qualification and latest result register
// Assumes: timer trigger inputs and converter core signals synchronous to clk_sys
// Notes: the analog core does timing; this block starts it and captures results
`timescale 1ns/1ps

//Contract
//- with scan off, the 3-bit start field chooses whether and what starts conversion.
//- code 0 starts nothing; code 1 starts a conversion at once.
//- code 2 starts on the chosen edge of 16-bit timer capture 0.
//- code 3 starts on the chosen edge of 32-bit timer capture 0.
//- codes 4 to 7 use 32-bit match 0, 1, then 16-bit match 0, 1.
//- match triggers arrive internally, independent of any pin routing.
//- edge bit matters only for the timer-triggered start codes.
//- edge bit clear starts conversion on a rising transition.
//- edge bit set starts conversion on a falling transition.
//- result field holds the 10-bit conversion value, valid while done reads one.
//- result runs from zero at low reference to 0x3FF at high reference.
//- a 3-bit field reports the channel that produced the stored result.
//- in scan mode overrun reads one when earlier results were overwritten.
//- done flag becomes one each time a conversion finishes.
//- done clears on reading the result register and on writing control.
//- control written mid-conversion sets done and begins a new conversion.
//- reserved bits of the result register always read zero.
//- scan mode repeatedly converts selected channels from the lowest, ignoring start; here scan runs only while the start code is 0.
module ast_start_ctrl #(
	parameter int ADDR_W = 32
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic timer16ZeroCaptureZero,
	input wire logic timer32ZeroCaptureZero,
	input wire logic timer32ZeroMatchZero,
	input wire logic timer32ZeroMatchOne,
	input wire logic timer16ZeroMatchZero,
	input wire logic timer16ZeroMatchOne,
	input wire logic convDone,
	input wire logic [9:0] convResult,
	output logic convStart,
	output logic [2:0] convChannel,
	output logic [2:0] scanResolutionSelect,
	output logic converterPowerOn,
	output logic convBusy
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	ast_pkg::ast_regs_t q;
	ast_pkg::ast_regs_t next_q;

	logic [5:0] trigIn;
	logic [5:0] trigRise;
	logic [5:0] trigFall;
	logic [5:0] trigHit;
	logic trigEdge;
	logic codeNone;
	logic codeTimer;
	logic [7:0] wrSel;
	logic wrScan;
	logic [2:0] wrStart;
	logic wrNow;
	logic ctrlHit;
	logic resHit;
	logic ctrlWr;
	logic ctrlRd;
	logic resRd;
	logic finish;
	logic lostResult;
	logic busyWrite;
	logic swGo;
	logic scanGo;
	logic setDone;
	logic clearDone;
	logic startReq;
	logic [2:0] startChan;
	logic [2:0] firstChan;
	logic [2:0] wrFirstChan;
	logic [2:0] scanNextChan;
	logic [31:0] ctrlWord;
	logic [31:0] resWord;

	// lowest selected channel at or above from, wrapping; channel 0 if none selected
	function automatic logic [2:0] pickChan(input logic [7:0] sel, input logic [2:0] from);
		logic [2:0] cand;
		logic found;
		logic [2:0] res;
		found = 1'b0;
		res = 3'h0;
		for (int i = 0; i < 8; i++) begin
			cand = 3'(from + 3'(i));
			if (!found && sel[cand]) begin
				found = 1'b1;
				res = cand;
			end
		end
		return res;
	endfunction : pickChan

	////////////////////////////////////////////////////////////////////////////////
	// trigger selection

	// index order follows start codes 2..7; matches come in as internal nets
	// line 0: code 2, 16-bit timer capture 0
	// line 1: code 3, 32-bit timer capture 0
	// line 2: code 4, 32-bit timer match 0
	// line 3: code 5, 32-bit timer match 1
	// line 4: code 6, 16-bit timer match 0
	// line 5: code 7, 16-bit timer match 1
	assign trigIn = {timer16ZeroMatchOne, timer16ZeroMatchZero, timer32ZeroMatchOne,
		timer32ZeroMatchZero, timer32ZeroCaptureZero,
		timer16ZeroCaptureZero};

	// per-line history, so changing the selection never fakes an edge
	for (genvar i = 0; i < 6; i++) begin : g_trig
		assign trigRise[i] = ~q.trigPrev[i] & trigIn[i];
		assign trigFall[i] = q.trigPrev[i] & ~trigIn[i];
		assign trigHit[i] = q.ctrlEdge ? trigFall[i] : trigRise[i];
	end

	////////////////////////////////////////////////////////////////////////////////
	// start code decode

	// codes 2..7 each own one trigger line; edge bit is ignored elsewhere
	always_comb begin
		codeNone = 1'b0;
		codeTimer = 1'b0;
		trigEdge = 1'b0;
		case (q.ctrlStart)
			ast_pkg::START_NONE: begin
				codeNone = 1'b1;
			end
			ast_pkg::START_NOW: begin
				// one start per control write, taken at the write itself
				codeTimer = 1'b0;
			end
			ast_pkg::START_FIRST_TIMER: begin
				codeTimer = 1'b1;
				trigEdge = trigHit[0];
			end
			3'h3: begin
				codeTimer = 1'b1;
				trigEdge = trigHit[1];
			end
			3'h4: begin
				codeTimer = 1'b1;
				trigEdge = trigHit[2];
			end
			3'h5: begin
				codeTimer = 1'b1;
				trigEdge = trigHit[3];
			end
			3'h6: begin
				codeTimer = 1'b1;
				trigEdge = trigHit[4];
			end
			3'h7: begin
				codeTimer = 1'b1;
				trigEdge = trigHit[5];
			end
			default: begin
				trigEdge = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// control write fields

	assign wrSel = regWdata[ast_pkg::CTL_SEL_LSB +: 8];
	assign wrScan = regWdata[ast_pkg::CTL_SCAN_BIT];
	assign wrStart = regWdata[ast_pkg::CTL_START_LSB +: 3];
	// start-now fires once per write; scan mode ignores it
	assign wrNow = (wrStart == ast_pkg::START_NOW) && !wrScan;

	////////////////////////////////////////////////////////////////////////////////
	// channel choice

	// software mode always takes the lowest selected channel
	assign firstChan = pickChan(q.ctrlSel, 3'h0);
	assign wrFirstChan = pickChan(wrSel, 3'h0);
	// scan walks upward and wraps past the top channel
	assign scanNextChan = q.scanActive ? pickChan(q.ctrlSel, 3'(q.curChan + 3'h1)) :
		firstChan;

	////////////////////////////////////////////////////////////////////////////////
	// register decode

	assign ctrlHit = (32'(regAddr) == ast_pkg::CONVERSION_CONTROL_ADDR);
	assign resHit = (32'(regAddr) == ast_pkg::LATEST_RESULT_ADDR);
	assign ctrlWr = regWrite & ctrlHit;
	assign ctrlRd = regRead & ctrlHit;
	assign resRd = regRead & resHit;

	////////////////////////////////////////////////////////////////////////////////
	// completion and start requests

	// a done pulse only counts while a conversion runs
	assign finish = convDone && (q.state == ast_pkg::AST_BUSY);
	// a result still flagged done when the next lands was never read
	assign lostResult = q.ctrlScan & q.resDone;
	// a write during a conversion restarts the core at once
	assign busyWrite = ctrlWr && (q.state == ast_pkg::AST_BUSY) && !convDone;
	// timer starts only with scan off and a timer code selected
	assign swGo = !q.ctrlScan && codeTimer && trigEdge;
	// scan chains conversions once the core is free; a write takes that cycle
	assign scanGo = q.ctrlScan && codeNone && !ctrlWr &&
		((q.state == ast_pkg::AST_IDLE) || finish);

	////////////////////////////////////////////////////////////////////////////////
	// read words

	always_comb begin
		// bits 31:28 read zero whatever was written
		ctrlWord = 32'h0000_0000;
		ctrlWord[ast_pkg::CTL_SEL_LSB +: 8] = q.ctrlSel;
		ctrlWord[ast_pkg::CTL_SCAN_BIT] = q.ctrlScan;
		ctrlWord[ast_pkg::CTL_RES_LSB +: 3] = q.ctrlScanRes;
		ctrlWord[ast_pkg::CTL_POWER_BIT] = q.ctrlPower;
		ctrlWord[ast_pkg::CTL_START_LSB +: 3] = q.ctrlStart;
		ctrlWord[ast_pkg::CTL_EDGE_BIT] = q.ctrlEdge;
	end

	always_comb begin
		// unlisted bits stay zero
		resWord = 32'h0000_0000;
		resWord[ast_pkg::RES_VALUE_LSB +: 10] = q.resValue;
		resWord[ast_pkg::RES_CHAN_LSB +: 3] = q.resChan;
		resWord[ast_pkg::RES_OVERRUN_BIT] = q.resOverrun;
		resWord[ast_pkg::RES_DONE_BIT] = q.resDone;
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_q = q;
		next_q.startPulse = 1'b0;
		next_q.trigPrev = trigIn;
		setDone = 1'b0;
		clearDone = 1'b0;
		startReq = 1'b0;
		startChan = q.curChan;

		// completion: every result field lands in the same cycle
		if (finish) begin
			next_q.resValue = convResult;
			next_q.resChan = q.curChan;
			next_q.resOverrun = lostResult;
			setDone = 1'b1;
			next_q.state = ast_pkg::AST_IDLE;
		end

		if (resRd) begin
			clearDone = 1'b1;
		end

		// start sources under software control
		// timer trigger
		if (swGo) begin
			startReq = 1'b1;
			startChan = firstChan;
		end
		// scan step
		if (scanGo) begin
			startReq = 1'b1;
			startChan = scanNextChan;
			next_q.scanActive = 1'b1;
		end
		if (!q.ctrlScan) begin
			next_q.scanActive = 1'b0;
		end

		// control write wins over triggers seen in the same cycle
		if (ctrlWr) begin
			next_q.ctrlSel = wrSel;
			next_q.ctrlScan = wrScan;
			next_q.ctrlScanRes = regWdata[ast_pkg::CTL_RES_LSB +: 3];
			next_q.ctrlPower = regWdata[ast_pkg::CTL_POWER_BIT];
			next_q.ctrlStart = wrStart;
			next_q.ctrlEdge = regWdata[ast_pkg::CTL_EDGE_BIT];
			// a write always clears done; a restart sets it again below
			clearDone = 1'b1;
			startReq = 1'b0;
			// scan off also ends a running chain
			if (!wrScan) begin
				next_q.scanActive = 1'b0;
			end
			if (busyWrite) begin
				setDone = 1'b1;
				startReq = 1'b1;
				startChan = wrFirstChan;
			end else if (wrNow) begin
				startReq = 1'b1;
				startChan = wrFirstChan;
			end
		end

		// hardware set wins over a clear in the same cycle
		next_q.resDone = (q.resDone & ~clearDone) | setDone;

		if (startReq) begin
			next_q.startPulse = 1'b1;
			next_q.curChan = startChan;
			next_q.state = ast_pkg::AST_BUSY;
		end

		// read data one cycle after the strobe, pre-update values
		case ({ctrlRd, resRd})
			2'b10: begin
				next_q.rdData = ctrlWord;
			end
			2'b01: begin
				next_q.rdData = resWord;
			end
			default: begin
				// idle or unmapped address reads zero
				next_q.rdData = 32'h0000_0000;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q.ctrlSel <= ast_pkg::SEL_RESET;
			q.ctrlScan <= 1'b0;
			q.ctrlScanRes <= ast_pkg::RES_SELECT_RESET;
			q.ctrlPower <= 1'b0;
			q.ctrlStart <= ast_pkg::START_RESET;
			q.ctrlEdge <= 1'b0;
			q.trigPrev <= 6'h00;
			q.state <= ast_pkg::AST_IDLE;
			q.scanActive <= 1'b0;
			q.curChan <= 3'h0;
			q.resValue <= 10'h000;
			q.resChan <= 3'h0;
			q.resOverrun <= 1'b0;
			q.resDone <= 1'b0;
			q.startPulse <= 1'b0;
			q.rdData <= 32'h0000_0000;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	// zero except in the cycle after a read strobe
	assign regRdata = q.rdData;
	// one cycle wide; a restart gives a fresh pulse while busy stays high
	assign convStart = q.startPulse;
	// holds the channel of the running or last conversion
	assign convChannel = q.curChan;
	// resolution and power pass straight through; the core owns their timing
	assign scanResolutionSelect = q.ctrlScanRes;
	assign converterPowerOn = q.ctrlPower;
	// busy drops only when a done pulse lands with no restart behind it
	assign convBusy = (q.state == ast_pkg::AST_BUSY);

endmodule : ast_start_ctrl

// >>> test/ast_start_ctrl_chk.sv
// Purpose: port checks for ast_start_ctrl
// Assumes: one clock, async low reset
// Notes: result word is seen the cycle after its read strobe
`timescale 1ns/1ps
module ast_start_ctrl_chk #(
	parameter int ADDR_W = 32
) (
	input logic clk_sys,
	input logic rst_n,
	input logic [ADDR_W-1:0] regAddr,
	input logic [31:0] regWdata,
	input logic regWrite,
	input logic regRead,
	input logic [31:0] regRdata,
	input logic convDone,
	input logic [9:0] convResult,
	input logic convStart,
	input logic [2:0] convChannel,
	input logic convBusy
);
	logic rdRes;
	logic wrCtl;
	assign rdRes = regRead && regAddr == ADDR_W'(ast_pkg::LATEST_RESULT_ADDR);
	assign wrCtl = regWrite && regAddr == ADDR_W'(ast_pkg::CONVERSION_CONTROL_ADDR);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	// gap cycle free of strobes so nothing clears done early
	sequence doneThenRead;
		convBusy && convDone ##1 !regRead && !regWrite ##1 rdRes;
	endsequence
	sequence readGapRead;
		rdRes && !convDone ##1 !convDone && !regWrite ##1 rdRes && !convDone;
	endsequence
	resv_zero_a: assert property (rdRes |=> regRdata[29:27] == 3'h0
		&& regRdata[23:16] == 8'h00 && regRdata[5:0] == 6'h00) else $error("reserved set");
	now_start_a: assert property (wrCtl && regWdata[26:24] == 3'h1 && !regWdata[16]
		|=> convStart) else $error("no start");
	none_start_a: assert property (wrCtl && regWdata[26:24] == 3'h0 && !regWdata[16]
		&& !convBusy |=> !convStart) else $error("stray start");
	start_busy_a: assert property (convStart |-> convBusy) else $error("idle start");
	result_read_a: assert property (doneThenRead |=> regRdata[31]
		&& regRdata[15:6] == $past(convResult, 3)
		&& regRdata[26:24] == $past(convChannel, 3)) else $error("bad result");
	read_clears_a: assert property (readGapRead |=> !regRdata[31]) else $error("done kept");
	busy_write_a: assert property (wrCtl && convBusy && !convDone
		|=> convStart) else $error("no restart");
	write_done_a: assert property (wrCtl && convBusy && !convDone
		##1 !regRead && !regWrite && !convDone ##1 rdRes |=> regRdata[31]) else $error("no done");
endmodule : ast_start_ctrl_chk

bind ast_start_ctrl ast_start_ctrl_chk #(.ADDR_W(ADDR_W)) chk (.*);

// >>> test/ast_timer_model.sv
// Purpose: timer trigger model
// Assumes: one pulse at a time
// Notes: pulse is high two cycles, a rise then a fall
`timescale 1ns/1ps
module ast_timer_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pulseReq,
	input wire logic [2:0] pulseLine,
	output logic [5:0] trig
);
	logic [1:0] hold;
	// match lines feed the converter directly, no pin involved
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trig <= 6'h00;
			hold <= 2'h0;
		end else if (pulseReq) begin
			trig[pulseLine] <= 1'b1;
			hold <= 2'h2;
		end else if (hold != 2'h0) begin
			hold <= hold - 2'h1;
			if (hold == 2'h1) trig <= 6'h00;
		end
	end
endmodule : ast_timer_model

// >>> test/tb_adc_start_trigger_and_result.sv
// Purpose: bench for ast_start_ctrl
// Assumes: bench pulses convDone in place of the core
// Notes: timer lines come from ast_timer_model
`timescale 1ns/1ps
module tb_adc_start_trigger_and_result;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] regAddr = 32'h0;
	logic [31:0] regWdata = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdata;
	logic convDone = 1'b0;
	logic [9:0] convResult = 10'h0;
	logic convStart;
	logic [2:0] convChannel;
	logic convBusy;
	logic [2:0] scanResolutionSelect;
	logic converterPowerOn;
	logic pulseReq = 1'b0;
	logic [2:0] pulseLine = 3'h0;
	logic [5:0] trig;
	logic [31:0] rv;
	int badCount = 0;
	int testsRun = 0;
	int cyc = 0;
	int f;
	int k;
	localparam logic [31:0] CA = ast_pkg::CONVERSION_CONTROL_ADDR;
	localparam logic [31:0] RA = ast_pkg::LATEST_RESULT_ADDR;
	always #20 clk_sys = ~clk_sys;
	ast_timer_model tm (.*);
	ast_start_ctrl dut (.*, .timer16ZeroCaptureZero(trig[0]), .timer32ZeroCaptureZero(trig[1]),
		.timer32ZeroMatchZero(trig[2]), .timer32ZeroMatchOne(trig[3]),
		.timer16ZeroMatchZero(trig[4]), .timer16ZeroMatchOne(trig[5]));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		testsRun++;
		if (s !== e) begin
			badCount++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wrReg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wrReg
	task automatic rdReg(input logic [31:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 rv = regRdata;
	endtask : rdReg
	task automatic fin(input logic [9:0] v);
		@(posedge clk_sys);
		convDone <= 1'b1;
		convResult <= v;
		@(posedge clk_sys);
		convDone <= 1'b0;
	endtask : fin
	// counts starts over eight cycles after one pulse; f is the first
	task automatic watch(input logic [2:0] ln);
		f = 0;
		k = 0;
		@(posedge clk_sys);
		pulseLine <= ln;
		pulseReq <= 1'b1;
		@(posedge clk_sys);
		pulseReq <= 1'b0;
		for (int n = 1; n <= 8; n++) begin
			if (n > 1) @(posedge clk_sys);
			#1;
			if (convStart === 1'b1) begin
				k++;
				if (f == 0) f = n;
			end
		end
	endtask : watch
	task automatic summarize();
		$display("checks %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			badCount++;
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdReg(CA);
		chk("ctl reset", rv, 32'h0000_0001);
		rdReg(RA);
		chk("res reset", rv, 32'h0);
		rdReg(32'h4001_C008);
		chk("unmapped", rv, 32'h0);
		chk("ctl outs", {scanResolutionSelect, converterPowerOn}, 4'h0);
		wrReg(CA, 32'h002A_0000);
		#1 chk("ctl outs", {scanResolutionSelect, converterPowerOn}, 4'hB);
		rdReg(CA);
		chk("ctl read", rv, 32'h002A_0000);
		$display("test reset done");
		wrReg(CA, 32'h0100_0008);
		#1 chk("start", {28'h0, convStart, convChannel}, 32'hB);
		fin(10'h3FF);
		rdReg(RA);
		chk("result", rv, 32'h8300_FFC0);
		rdReg(RA);
		chk("reread", rv, 32'h0300_FFC0);
		$display("test now done");
		for (int c = 2; c < 8; c++) begin
			for (int e = 0; e < 2; e++) begin
				wrReg(CA, {4'h0, e[0], c[2:0], 24'h1});
				watch(3'((c - 1) % 6));
				chk("other line", k, 0);
				watch(3'(c - 2));
				chk("starts", k, 1);
				chk("delay", f, e ? 4 : 2);
				fin(10'(c));
			end
		end
		$display("test trigger done");
		wrReg(CA, 32'h0100_0001);
		wrReg(CA, 32'h0000_0004);
		#1 chk("restart", {28'h0, convStart, convChannel}, 32'hA);
		rdReg(RA);
		chk("done set", rv[31], 1'b1);
		fin(10'h0);
		wrReg(CA, 32'h0);
		rdReg(RA);
		chk("write clears", rv[31], 1'b0);
		$display("test rewrite done");
		wrReg(CA, 32'h0001_0006);
		repeat (2) @(posedge clk_sys);
		#1 chk("scan chan", convChannel, 3'h1);
		fin(10'h0AA);
		repeat (3) @(posedge clk_sys);
		fin(10'h155);
		rdReg(RA);
		chk("overrun", rv, 32'hC200_5540);
		wrReg(CA, 32'h0);
		fin(10'h0);
		$display("test scan done");
		summarize();
	end
endmodule : tb_adc_start_trigger_and_result
